/* logic/gpf_exception_routing.sv */
// Protection fault routing and speculation containment.
// Assumes all requests come from core-clock logic, one-cycle pulses.
//
// Contract
// RL1: Fault class follows select bit, class picks level
// RL2: Select one: lower-level fault becomes check exception
// RL3: Select zero: lower-level fault becomes abort
// RL4: Check exceptions always go to top level
// RL5: Aborts carry dedicated protection fault status codes
// RL6: Top-level faults abort to top level
// RL7: Level 2 or stage-2 table faults go to 2
// RL8: Hardware stage-2 table updates count as table accesses
// RL9: Levels 0/1: level 1 only if both bits zero
// RL10: Stage-2 table abort records input intermediate address
// RL11: Abort records virtual address at target level
// RL12: Realm asynchronous routing equals non-secure routing
// RL13: Top-level routing ignores security select bits
// RL14: Four distinct physical address spaces
// RL15: Unresolved-check walk reads are speculative
// RL16: Faulting speculative load data never forwarded
// RL17: Faulting stage-1 entry gives no walk address
// RL18: Faulting speculative fetch updates no state
// RL19: Elide clear: unresolved walk data stays unused
// RL20: Ordering regions only in non-secure space
// RL21: Route top level, then table, then bits
`timescale 1ns/100ps
module gpf_exception_routing (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic FAULT_VALID,
  input gpf_pkg::fault_req_s FAULT_REQ,
  output logic EXC_VALID,
  output gpf_pkg::exc_s EXC_OUT,
  input wire logic ASYNC_VALID,
  input wire logic [1:0] ASYNC_CUR_EL,
  output logic ASYNC_TAKE,
  output logic [1:0] ASYNC_TARGET_EL,
  input wire logic LD_SPEC,
  input wire logic LD_GPC_FAULT,
  output logic LD_FWD_EN,
  input wire logic WALK_VALID,
  input wire logic WALK_CHECK_DONE,
  input wire logic WALK_CHECK_FAULT,
  input wire logic WALK_S1_ENTRY,
  input wire logic WALK_S2_ENABLED,
  input wire logic WALK_S2_TABLE_DESC,
  output logic WALK_SPECULATIVE,
  output logic WALK_ADDR_USE_EN,
  output logic WALK_SYND_USE_EN,
  input wire logic IF_SPEC,
  input wire logic IF_GPC_FAULT,
  output logic IF_STATE_UPD_EN,
  input gpf_pkg::pas_e LOR_REQ_PAS,
  output logic LOR_DEF_EN
);
  import gpf_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;  // Software configuration bits
  logic [31:0] far1_reg, far2_reg, far3_reg;  // Per-level virtual fault address
  logic [31:0] ipa_reg;  // Intermediate address of table faults
  exc_s exc_reg, exc_next;
  logic exc_vld_reg;
  logic upd_ipa;  // Record intermediate address this fault
  logic [31:0] rdata_reg;
  logic [1:0] async_el_next;

  // Routing decision for one protection fault
  always_comb begin
    exc_next = '{cls: CLS_NONE, el: EL3, fsc: FSC_NONE, vaddr: FAULT_REQ.vaddr};
    upd_ipa = 1'b0;
    if (FAULT_REQ.src_el != EL3 && ctrl_reg[CB_FRS]) begin
      // Check exception class goes to top level [RL1] [RL2] [RL4]
      exc_next.cls = CLS_GPC;
      exc_next.el = EL3;
      exc_next.fsc = 6'(FSC_GPF_BASE + {4'h0, FAULT_REQ.tbl_level});
      upd_ipa = FAULT_REQ.s2_table;
    end else begin
      // Abort class, status code marks protection fault [RL3] [RL5]
      exc_next.cls = FAULT_REQ.is_instr ? CLS_IABT : CLS_DABT;
      exc_next.fsc = 6'(FSC_GPF_BASE + {4'h0, FAULT_REQ.tbl_level});
      if (FAULT_REQ.src_el == EL3) begin
        exc_next.el = EL3;  // [RL6] [RL21]
      end else if (FAULT_REQ.src_el == EL2 || FAULT_REQ.s2_table) begin
        // Hardware table updates arrive flagged as table accesses [RL7] [RL8] [RL21]
        exc_next.el = EL2;
        upd_ipa = FAULT_REQ.s2_table;  // [RL10]
      end else if (!ctrl_reg[CB_TGE] && !ctrl_reg[CB_HFR]) begin
        exc_next.el = EL1;  // [RL9]
      end else begin
        exc_next.el = EL2;  // [RL9]
      end
    end
  end

  // Exception output stage, one-cycle pulse
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      exc_vld_reg <= 1'b0;
      exc_reg <= '{cls: CLS_NONE, el: EL0, fsc: FSC_NONE, vaddr: 32'h0};
    end else begin
      exc_vld_reg <= FAULT_VALID;
      if (FAULT_VALID) begin
        exc_reg <= exc_next;
      end
    end
  end
  assign EXC_VALID = exc_vld_reg;
  assign EXC_OUT = exc_reg;

  // Fault address capture at the target level
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      far1_reg <= 32'h0;
      far2_reg <= 32'h0;
      far3_reg <= 32'h0;
      ipa_reg <= 32'h0;
    end else if (FAULT_VALID) begin
      case (exc_next.el)
        EL1: far1_reg <= FAULT_REQ.vaddr;  // [RL11]
        EL2: far2_reg <= FAULT_REQ.vaddr;  // [RL11]
        default: far3_reg <= FAULT_REQ.vaddr;  // [RL11]
      endcase
      if (upd_ipa) begin
        ipa_reg <= FAULT_REQ.ipa;  // [RL10]
      end
    end
  end

  // Control register write; other offsets are read-only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
    end else if (REG_WR && REG_ADDR == CTRL_OFS) begin
      ctrl_reg <= REG_WDATA[CTRL_W-1:0];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RST || !REG_RD) begin
      rdata_reg <= 32'h0;
    end else if (REG_ADDR == CTRL_OFS) begin
      rdata_reg <= {25'h0, ctrl_reg};
    end else if (REG_ADDR == STAT_OFS) begin
      rdata_reg <= {22'h0, exc_reg.fsc, exc_reg.el, exc_reg.cls};
    end else if (REG_ADDR == FAR1_OFS) begin
      rdata_reg <= far1_reg;
    end else if (REG_ADDR == FAR2_OFS) begin
      rdata_reg <= far2_reg;
    end else if (REG_ADDR == FAR3_OFS) begin
      rdata_reg <= far3_reg;
    end else if (REG_ADDR == IPA_OFS) begin
      rdata_reg <= ipa_reg;
    end else begin
      rdata_reg <= 32'h0;  // Unmapped reads as zero
    end
  end
  assign REG_RDATA = rdata_reg;

  // Asynchronous routing; realm shares the non-secure select value
  always_comb begin
    if (ASYNC_CUR_EL == EL3) begin
      async_el_next = EL3;  // Select bits never consulted [RL13]
    end else if (ctrl_reg[CB_SSS] || ctrl_reg[CB_SHE]) begin
      // Extension bit ignored, so realm routes as non-secure [RL12]
      if (ctrl_reg[CB_TGE] || ASYNC_CUR_EL == EL2) begin
        async_el_next = EL2;
      end else begin
        async_el_next = EL1;
      end
    end else begin
      // Secure without its hypervisor: stays at level 1 or above
      async_el_next = (ASYNC_CUR_EL == EL0) ? EL1 : ASYNC_CUR_EL;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ASYNC_TAKE <= 1'b0;
      ASYNC_TARGET_EL <= EL0;
    end else begin
      ASYNC_TAKE <= ASYNC_VALID;
      if (ASYNC_VALID) begin
        ASYNC_TARGET_EL <= async_el_next;
      end
    end
  end

  // Speculation gates; blocking is by enable so timing never varies with data
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      LD_FWD_EN <= 1'b0;
      IF_STATE_UPD_EN <= 1'b0;
      LOR_DEF_EN <= 1'b0;
    end else begin
      LD_FWD_EN <= !(LD_SPEC && LD_GPC_FAULT);  // [RL16]
      IF_STATE_UPD_EN <= !(IF_SPEC && IF_GPC_FAULT);  // [RL18]
      LOR_DEF_EN <= (LOR_REQ_PAS == PAS_NS);  // [RL14] [RL20]
    end
  end

  // Walk data use: elision only covers stage-2 table descriptors
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      WALK_SPECULATIVE <= 1'b0;
      WALK_ADDR_USE_EN <= 1'b0;
      WALK_SYND_USE_EN <= 1'b0;
    end else begin
      WALK_SPECULATIVE <= WALK_VALID && !WALK_CHECK_DONE;  // [RL15]
      // A flagged stage-1 fault with stage 2 enabled blocks the address even before resolution
      WALK_ADDR_USE_EN <= WALK_VALID && !(WALK_CHECK_FAULT
                          && WALK_S1_ENTRY && WALK_S2_ENABLED)  // [RL17]
                          && ((WALK_CHECK_DONE && !WALK_CHECK_FAULT)
                          || (ctrl_reg[CB_TCE] && WALK_S2_TABLE_DESC
                          && !WALK_CHECK_DONE));  // [RL19]
      WALK_SYND_USE_EN <= WALK_VALID && WALK_CHECK_DONE && !WALK_CHECK_FAULT;  // [RL19]
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence lower_fault_s;
    FAULT_VALID && FAULT_REQ.src_el != EL3;
  endsequence
  sequence top_fault_s;
    FAULT_VALID && FAULT_REQ.src_el == EL3;
  endsequence

  check_class_a: assert property (lower_fault_s ##0 ctrl_reg[CB_FRS] |=> // [RL2]
    EXC_VALID && EXC_OUT.cls == CLS_GPC) else $error("check exception class wrong");
  check_level_a: assert property (EXC_VALID && EXC_OUT.cls == CLS_GPC |-> // [RL4]
    EXC_OUT.el == EL3) else $error("check exception not at top level");
  abort_class_a: assert property (lower_fault_s ##0 !ctrl_reg[CB_FRS] |=> // [RL3]
    EXC_OUT.cls inside {CLS_IABT, CLS_DABT}) else $error("abort class wrong");
  abort_fsc_a: assert property (EXC_VALID |-> EXC_OUT.fsc >= FSC_GPF_BASE) // [RL5]
    else $error("status code not protection fault");
  top_abort_a: assert property (top_fault_s |=> EXC_OUT.el == EL3) // [RL6]
    else $error("top-level fault routed down");
  table_route_a: assert property (lower_fault_s ##0 !ctrl_reg[CB_FRS] // [RL7]
    ##0 FAULT_REQ.s2_table |=> EXC_OUT.el == EL2) else $error("table fault not at 2");
  low_route_a: assert property (lower_fault_s ##0 !ctrl_reg[CB_FRS] ##0 // [RL9]
    FAULT_REQ.src_el != EL2 && !FAULT_REQ.s2_table |=>
    EXC_OUT.el == ($past(ctrl_reg[CB_TGE] || ctrl_reg[CB_HFR]) ? EL2 : EL1))
    else $error("level 0/1 abort routed wrong");
  ipa_save_a: assert property (lower_fault_s ##0 FAULT_REQ.s2_table |=> // [RL10]
    ipa_reg == $past(FAULT_REQ.ipa)) else $error("intermediate address not saved");
  far_save_a: assert property (EXC_VALID && EXC_OUT.el == EL1 |-> // [RL11]
    far1_reg == EXC_OUT.vaddr) else $error("virtual address not saved");
  async_top_a: assert property (ASYNC_VALID && ASYNC_CUR_EL == EL3 |=> // [RL13]
    ASYNC_TAKE && ASYNC_TARGET_EL == EL3) else $error("top-level async moved");
  load_block_a: assert property (LD_SPEC && LD_GPC_FAULT |=> !LD_FWD_EN) // [RL16]
    else $error("faulting load data forwarded");
  fetch_block_a: assert property (IF_SPEC && IF_GPC_FAULT |=> !IF_STATE_UPD_EN) // [RL18]
    else $error("faulting fetch updated state");
  walk_hold_a: assert property (WALK_VALID && !WALK_CHECK_DONE && !ctrl_reg[CB_TCE] // [RL19]
    |=> !WALK_ADDR_USE_EN && !WALK_SYND_USE_EN && WALK_SPECULATIVE)
    else $error("unresolved walk data used");
  s1_block_a: assert property (WALK_VALID && WALK_CHECK_FAULT && WALK_S1_ENTRY // [RL17]
    && WALK_S2_ENABLED |=> !WALK_ADDR_USE_EN) else $error("faulting entry address used");
  lor_ns_a: assert property (LOR_DEF_EN |-> $past(LOR_REQ_PAS) == PAS_NS) // [RL20]
    else $error("ordering region outside non-secure space");
endmodule

/* logic/gpf_pkg.sv */
// Shared constants and carriers for the protection fault router.
// Assumes one core clock; all requesters sit in that clock domain.
package gpf_pkg;
  // Privilege levels
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;
  // Dedicated abort status code base, plus table level
  localparam logic [5:0] FSC_GPF_BASE = 6'h28;
  localparam logic [5:0] FSC_NONE = 6'h00;
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FAR1_OFS = 8'h08;
  localparam logic [7:0] FAR2_OFS = 8'h0c;
  localparam logic [7:0] FAR3_OFS = 8'h10;
  localparam logic [7:0] IPA_OFS = 8'h14;
  // Control field positions
  localparam int CB_FRS = 0;  // fault_report_select
  localparam int CB_TGE = 1;  // trap_general_bit
  localparam int CB_HFR = 2;  // hyp_fault_route_bit
  localparam int CB_TCE = 3;  // table_check_elide
  localparam int CB_SSS = 4;  // security_state_select
  localparam int CB_SSE = 5;  // security_state_extension
  localparam int CB_SHE = 6;  // secure_hyp_enable
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  // Exception classes
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0, CLS_GPC = 2'h1, CLS_IABT = 2'h3, CLS_DABT = 2'h2
  } exc_class_e;
  // Four physical address spaces
  typedef enum logic [1:0] {
    PAS_SEC = 2'h0, PAS_NS = 2'h1, PAS_ROOT = 2'h2, PAS_REALM = 2'h3
  } pas_e;
  // One fault from the check pipeline
  typedef struct packed {
    logic [1:0] src_el;
    logic is_instr;
    logic s2_table;  // stage 2 table access, incl. hardware update
    logic [1:0] tbl_level;
    pas_e pas;
    logic [31:0] vaddr;
    logic [31:0] ipa;
  } fault_req_s;
  // One exception handed to entry logic
  typedef struct packed {
    exc_class_e cls;
    logic [1:0] el;
    logic [5:0] fsc;
    logic [31:0] vaddr;
  } exc_s;
endpackage

/* verif/gpf_check_pipe_model.sv */
// Stand-in for the translation and protection check pipeline.
// Assumes one core clock; one fault per call of send.
`timescale 1ns/100ps
module gpf_check_pipe_model (
  input wire logic clk,
  output logic fault_valid,
  output gpf_pkg::fault_req_s fault_req
);
  import gpf_pkg::*;
  // Quiet at start
  initial begin
    fault_valid = 1'b0;
    fault_req = '0;
  end
  // One-cycle pulse; hardware stage-2 updates come flagged as table accesses
  task automatic send(input fault_req_s r);
    @(posedge clk);
    fault_valid <= 1'b1;
    fault_req <= r;
    @(posedge clk);
    fault_valid <= 1'b0;
    // Inverted after release so a late capture shows up
    fault_req <= fault_req_s'(~r);
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the protection fault router.
// Assumes the pipeline model drives the fault port.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin total_checks++; if ((gt) !== (ex)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import gpf_pkg::*;
  logic sys_clk, rst, reg_wr, reg_rd, async_valid, ld_spec, ld_gpc_fault, ld_fwd_en;
  logic fault_valid, exc_valid, async_take, if_spec, if_gpc_fault, if_state_upd_en, lor_def_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] async_cur_el, async_target_el;
  logic [5:0] walk_in; // {s2desc, s2en, s1, fault, done, valid}
  logic [2:0] walk_out; // {synd, addr, spec}
  fault_req_s fault_req;
  exc_s exc_out;
  pas_e lor_req_pas;
  int fails, total_checks;
  gpf_check_pipe_model pipe_u (.clk(sys_clk), .fault_valid(fault_valid), .fault_req(fault_req));
  gpf_exception_routing dut_u (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FAULT_VALID(fault_valid), .FAULT_REQ(fault_req), .EXC_VALID(exc_valid), .EXC_OUT(exc_out),
    .ASYNC_VALID(async_valid), .ASYNC_CUR_EL(async_cur_el), .ASYNC_TAKE(async_take),
    .ASYNC_TARGET_EL(async_target_el), .LD_SPEC(ld_spec), .LD_GPC_FAULT(ld_gpc_fault),
    .LD_FWD_EN(ld_fwd_en), .WALK_VALID(walk_in[0]), .WALK_CHECK_DONE(walk_in[1]),
    .WALK_CHECK_FAULT(walk_in[2]), .WALK_S1_ENTRY(walk_in[3]), .WALK_S2_ENABLED(walk_in[4]),
    .WALK_S2_TABLE_DESC(walk_in[5]), .WALK_SPECULATIVE(walk_out[0]),
    .WALK_ADDR_USE_EN(walk_out[1]), .WALK_SYND_USE_EN(walk_out[2]), .IF_SPEC(if_spec),
    .IF_GPC_FAULT(if_gpc_fault), .IF_STATE_UPD_EN(if_state_upd_en),
    .LOR_REQ_PAS(lor_req_pas), .LOR_DEF_EN(lor_def_en));
  // Core clock, 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Register write, one strobe cycle
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Register read; data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Reset values, unmapped 0x18, read-only capture register FAR1
  task automatic t_regs();
    logic [31:0] d;
    for (int a = 0; a <= 'h18; a += 4) begin
      bus_rd(8'(a), d);
      `CHK("reset reg", 32'h0, d)
    end
    bus_wr(FAR1_OFS, 32'h5a5a_5a5a);
    bus_rd(FAR1_OFS, d);
    `CHK("far1 ro", 32'h0, d)
    bus_wr(CTRL_OFS, 32'hffff_ffff);
    bus_rd(CTRL_OFS, d);
    `CHK("ctrl", 32'h7f, d)
  endtask
  // Every select/trap/route setting against every source level, table or not
  task automatic t_route();
    fault_req_s r;
    exc_s e;
    logic [31:0] d;
    for (int i = 0; i < 64; i++) begin
      bus_wr(CTRL_OFS, {29'h0, i[5:3]});
      r = {i[1:0], i[0], i[2], i[4:3], PAS_NS, 24'h100000, i[7:0], 24'h200000, i[7:0]};
      e.vaddr = r.vaddr;
      e.fsc = FSC_GPF_BASE + 6'(r.tbl_level);
      // Check exception only below the top level with select set
      if (r.src_el != EL3 && i[3]) begin
        e.cls = CLS_GPC;
        e.el = EL3;
      end else begin
        e.cls = r.is_instr ? CLS_IABT : CLS_DABT;
        if (r.src_el == EL3) e.el = EL3;
        else if (r.src_el == EL2 || r.s2_table) e.el = EL2;
        else e.el = (i[5:4] == 2'h0) ? EL1 : EL2;
      end
      pipe_u.send(r);
      #1;
      `CHK("exc_valid", 1'b1, exc_valid)
      `CHK("exc_out", e, exc_out)
      bus_rd(8'h04 + {4'h0, e.el, 2'h0}, d);
      `CHK("far", r.vaddr, d)
      if (r.s2_table && e.el == EL2) begin
        bus_rd(IPA_OFS, d);
        `CHK("ipa", r.ipa, d)
      end
    end
  endtask
  // One asynchronous request under a given control word
  task automatic async_at(input logic [6:0] c, input logic [1:0] el, output logic [1:0] t);
    bus_wr(CTRL_OFS, {25'h0, c});
    @(posedge sys_clk);
    async_valid <= 1'b1;
    async_cur_el <= el;
    @(posedge sys_clk);
    async_valid <= 1'b0;
    #1 t = async_target_el;
    `CHK("async_take", 1'b1, async_take)
  endtask
  // Realm state against non-secure; top level against all select/extension settings, hyp enable clear
  task automatic t_async();
    logic [1:0] tn, tr;
    for (int el = 0; el < 4; el++) begin
      async_at(7'h10, 2'(el), tn);
      async_at(7'h30, 2'(el), tr);
      `CHK("ns route", (el == 0) ? EL1 : 2'(el), tn)
      `CHK("realm route", tn, tr)
    end
    for (int c = 0; c < 4; c++) begin
      async_at({1'b0, 2'(c), 4'h0}, EL3, tn);
      `CHK("top route", EL3, tn)
    end
  endtask
  // Speculative load and fetch gates, ordering region per address space
  task automatic t_spec();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      ld_spec <= 1'b1;
      if_spec <= 1'b1;
      ld_gpc_fault <= i[0];
      if_gpc_fault <= i[0];
      lor_req_pas <= pas_e'(i[1:0]);
      @(posedge sys_clk);
      #1;
      `CHK("ld_fwd_en", !i[0], ld_fwd_en)
      `CHK("if_state_upd_en", !i[0], if_state_upd_en)
      `CHK("lor_def_en", i[1:0] == PAS_NS, lor_def_en)
    end
  endtask
  // Walk gates; in = {elide, walk_in}, m masks outputs left open
  task automatic walk_case(input logic [6:0] in, input logic [2:0] ex, input logic [2:0] m);
    bus_wr(CTRL_OFS, {28'h0, in[6], 3'h0});
    @(posedge sys_clk);
    walk_in <= in[5:0];
    @(posedge sys_clk);
    #1;
    `CHK("walk gates", ex & m, walk_out & m)
  endtask
  task automatic t_walk();
    walk_case(7'h01, 3'b001, 3'b111);
    walk_case(7'h03, 3'b110, 3'b111);
    walk_case(7'h1f, 3'b000, 3'b010);
    walk_case(7'h61, 3'b011, 3'b011);
  endtask
  // Main sequence
  initial begin
    {reg_wr, reg_rd, async_valid, ld_spec, ld_gpc_fault, if_spec, if_gpc_fault} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    async_cur_el = '0;
    walk_in = '0;
    lor_req_pas = PAS_SEC;
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_async();
    t_spec();
    t_walk();
    give_verdict();
  end
  // Watchdog, far beyond the roughly 500 cycles needed
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule
